// ==== hw/arc_map.svh ====
// Constants of the analog reference conditioning block: codes, defaults, thresholds, times
`ifndef ARC_MAP_SVH
`define ARC_MAP_SVH
// Register offsets (word addresses on the plain port)
`define ARC_OFF_CTRL        4'h0
`define ARC_OFF_TOL         4'h1
`define ARC_OFF_MINOUT      4'h2
`define ARC_OFF_PT1         4'h3
`define ARC_OFF_PT2         4'h4
`define ARC_OFF_STATUS      4'h5
`define ARC_OFF_RESULT      4'h6
`define ARC_OFF_HOLD        4'h7
// Control field positions
`define ARC_CTRL_TC_LSB     0
`define ARC_CTRL_MON_LSB    4
`define ARC_CTRL_M1_LSB     8
`define ARC_CTRL_M2_LSB     12
`define ARC_CTRL_CUR_BIT    16
// Reset values
`define ARC_RST_TC          4'h0
`define ARC_RST_MON         2'h0
`define ARC_RST_M1          3'h1
`define ARC_RST_M2          3'h3
`define ARC_RST_TOL         16'h0147
`define ARC_RST_MINOUT      16'h0000
`define ARC_RST_X1          16'h0147
`define ARC_RST_Y1          16'h0000
`define ARC_RST_X2          16'h3eb8
`define ARC_RST_Y2          16'h3fff
`define ARC_RST_HOLD        32'h0000_0000
// Full scale is 16'h3fff = 100 % (10 V or 20 mA); tolerance max 25 %
`define ARC_TOL_MAX         16'h1000
`define ARC_UNDER_V         16'h0666
`define ARC_UNDER_I         16'h0666
`define ARC_CUR_MAX         16'h3fff
// Stop behaviour codes
`define ARC_STOP_COAST      2'h0
`define ARC_STOP_DECEL      2'h2
// Sample tick: one input sample per millisecond at 125 MHz
`define ARC_SAMPLE_NS       1000000
`define ARC_CLK_NS          8
`define ARC_SAMPLE_CYC      (`ARC_SAMPLE_NS / `ARC_CLK_NS)
// Signal source code of input one digital value
`define ARC_SRC_IN1_DIG     8'h4c
`endif

// ==== hw/arc_pkg.sv ====
// Types of the analog reference conditioning block
package arc_pkg;
    // Monitoring modes
    typedef enum logic [1:0] {
        ARC_MON_OFF   = 2'b00,
        ARC_MON_WARN  = 2'b01,
        ARC_MON_DECEL = 2'b10,
        ARC_MON_COAST = 2'b11
    } arc_mon_t;
    // Multifunction input modes
    typedef enum logic [2:0] {
        ARC_MF_NONE   = 3'b000,
        ARC_MF_VOLT   = 3'b001,
        ARC_MF_CUR20  = 3'b010,
        ARC_MF_DIG_LO = 3'b011,
        ARC_MF_DIG_HI = 3'b100,
        ARC_MF_CUR420 = 3'b101,
        ARC_MF_VCHAR  = 3'b110,
        ARC_MF_ICHAR  = 3'b111
    } arc_mf_t;
    // Supervision flags as a group
    typedef struct packed {
        logic       warn;
        logic       fault;
        logic       stop_req;
        logic [1:0] stop_kind;
        logic       error;
        logic       overcur;
    } arc_sup_t;
    // Register port request
    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } arc_req_t;
endpackage : arc_pkg

// ==== hw/arc_cond.sv ====
// Analog reference conditioning: filter, hysteresis, characteristic, supervision
`include "arc_map.svh"
module arc_cond
    import arc_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = `ARC_SAMPLE_CYC  // Cycles between input samples
)(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // Register port
    input  wire logic [3:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [31:0]         reg_rdata,
    // Converter samples, signed, 16'h3fff = full scale
    input  wire logic signed [15:0]  input_one_sample,
    input  wire logic signed [15:0]  input_two_analog_value,
    // Pins used as digital inputs
    input  wire logic                multifunction_input_one,
    input  wire logic                multifunction_input_two,
    // Drive side
    input  wire logic                start_signal,
    output logic signed [15:0]       ref_out,
    output logic                     input_one_digital_value,
    output logic                     input_two_digital_value,
    output logic                     warn,
    output logic                     fault,
    output logic                     stop_req,
    output logic      [1:0]          stop_kind,
    output logic                     error_flag,
    output logic                     overcur_fault
);
    // Configuration registers
    logic [3:0]          tc_q;          // Filter constant select
    arc_mon_t            mon_q;         // Monitoring mode
    arc_mf_t             m1_q;          // Input one mode
    arc_mf_t             m2_q;          // Input two mode
    logic                cur_q;         // Input one current range
    logic [15:0]         tol_q;         // Tolerance band
    logic signed [15:0]  minout_q;      // Minimum output level
    logic signed [15:0]  x1_q, y1_q;    // First point
    logic signed [15:0]  x2_q, y2_q;    // Second point
    logic [31:0]         hold_q;        // Holding time in cycles
    // Sample path state
    logic [31:0]         tick_cnt_q;    // Sample tick divider
    logic                tick;          // One sample period elapsed
    logic signed [31:0]  filt_q;        // Filter state, 16 fraction bits
    logic signed [15:0]  filt_out;      // Filtered sample
    logic                hyst_pos_q;    // Hysteresis side memory
    // Synchronisers
    logic [1:0]          sync1_q, sync2_q, syncs_q;
    // Supervision state
    logic                latched_q;     // Mode 2 stop pending restart
    logic [31:0]         hold_cnt_q;    // Holding time counter
    logic                start_seen_q;  // Start went on after stop
    arc_sup_t            sup_d, sup_q;
    logic [31:0]         rd_d;

    // Register writes; tolerance clipped to 25 %
    // Bad addresses ignored
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            tc_q     <= `ARC_RST_TC;
            mon_q    <= ARC_MON_OFF;
            m1_q     <= arc_mf_t'(`ARC_RST_M1);
            m2_q     <= arc_mf_t'(`ARC_RST_M2);
            cur_q    <= 1'b0;
            tol_q    <= `ARC_RST_TOL;
            minout_q <= `ARC_RST_MINOUT;
            x1_q     <= `ARC_RST_X1;
            y1_q     <= `ARC_RST_Y1;
            x2_q     <= `ARC_RST_X2;
            y2_q     <= `ARC_RST_Y2;
            hold_q   <= `ARC_RST_HOLD;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                `ARC_OFF_CTRL:
                begin
                    tc_q  <= reg_wdata[`ARC_CTRL_TC_LSB +: 4];
                    mon_q <= arc_mon_t'(reg_wdata[`ARC_CTRL_MON_LSB +: 2]);
                    m1_q  <= arc_mf_t'(reg_wdata[`ARC_CTRL_M1_LSB +: 3]);
                    m2_q  <= arc_mf_t'(reg_wdata[`ARC_CTRL_M2_LSB +: 3]);
                    cur_q <= reg_wdata[`ARC_CTRL_CUR_BIT];
                end
                // Clip to the 25 % ceiling
                `ARC_OFF_TOL:    tol_q <= (reg_wdata[15:0] > `ARC_TOL_MAX) ?
                                          `ARC_TOL_MAX : reg_wdata[15:0];
                `ARC_OFF_MINOUT: minout_q <= reg_wdata[15:0];
                `ARC_OFF_PT1:
                begin
                    x1_q <= reg_wdata[15:0];
                    y1_q <= reg_wdata[31:16];
                end
                `ARC_OFF_PT2:
                begin
                    x2_q <= reg_wdata[15:0];
                    y2_q <= reg_wdata[31:16];
                end
                `ARC_OFF_HOLD:   hold_q <= reg_wdata;
                default:         ;
            endcase
        end
    end

    // Read data mux, unmapped reads zero
    // Status shows synced pins
    always_comb
    begin
        rd_d = 32'h0000_0000;
        unique case (reg_addr)
            `ARC_OFF_CTRL:   rd_d = {15'h0000, cur_q, 1'b0, m2_q, 1'b0, m1_q,
                                     2'h0, mon_q, tc_q};
            `ARC_OFF_TOL:    rd_d = {16'h0000, tol_q};
            `ARC_OFF_MINOUT: rd_d = {16'h0000, minout_q};
            `ARC_OFF_PT1:    rd_d = {y1_q, x1_q};
            `ARC_OFF_PT2:    rd_d = {y2_q, x2_q};
            `ARC_OFF_STATUS: rd_d = {16'h0000, `ARC_SRC_IN1_DIG,
                                     syncs_q, sup_q[4:0], latched_q};
            `ARC_OFF_RESULT: rd_d = {16'h0000, ref_out};
            `ARC_OFF_HOLD:   rd_d = hold_q;
            default:         rd_d = 32'h0000_0000;
        endcase
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            reg_rdata <= 32'h0000_0000;
        end
        else
        begin
            reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
        end
    end

    // Sample tick divider
    // Period SAMPLE_CYC
    assign tick = (tick_cnt_q == SAMPLE_CYC - 1);
    always_ff @(posedge clock)
    begin
        if (rst || tick)
            tick_cnt_q <= 32'h0000_0000;
        else
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end

    // Filter gain: shift approximating 1 ms / tau
    // Long taus share shifts
    function automatic logic [3:0] tc_shift(input logic [3:0] sel);
        unique case (sel)
            4'h1:    tc_shift = 4'h1;  // 2 ms
            4'h2:    tc_shift = 4'h2;  // 4 ms
            4'h3:    tc_shift = 4'h3;  // 8 ms
            4'h4:    tc_shift = 4'h4;  // 16 ms
            4'h5:    tc_shift = 4'h5;  // 32 ms
            4'h6:    tc_shift = 4'h6;  // 64 ms
            4'h7:    tc_shift = 4'h7;  // 128 ms
            4'h8:    tc_shift = 4'h8;  // 256 ms
            4'h9:    tc_shift = 4'h9;  // 512 ms
            4'ha:    tc_shift = 4'ha;  // 1000 ms
            4'hb:    tc_shift = 4'hb;  // 2000 ms
            4'hc:    tc_shift = 4'hb;  // 3000 ms
            4'hd:    tc_shift = 4'hc;  // 4000 ms
            4'he:    tc_shift = 4'hc;  // 5000 ms
            default: tc_shift = 4'h0;  // 0 ms
        endcase
    endfunction : tc_shift

    // Filter input error term
    logic signed [31:0] filt_in;
    logic signed [31:0] filt_err;
    assign filt_in  = {input_one_sample, 16'h0000};
    assign filt_err = filt_in - filt_q;

    // First-order recursive averager, one update per sample
    // Shift keeps sign
    always_ff @(posedge clock)
    begin
        if (rst)
            filt_q <= 32'sh0000_0000;
        else if (tc_q == 4'h0)
            filt_q <= filt_in;
        else if (tick)
            filt_q <= filt_q + (filt_err >>> tc_shift(tc_q));
    end
    assign filt_out = (tc_q == 4'h0) ? input_one_sample : filt_q[31:16];

    // Two-point characteristic
    // Equal X gives Y1
    logic signed [16:0] dx_in, dy, dx;
    logic signed [33:0] prod;
    logic signed [33:0] quot;
    logic signed [15:0] char_val;
    logic               is_char;
    assign is_char  = (m1_q == ARC_MF_VCHAR) || (m1_q == ARC_MF_ICHAR);
    assign dx_in    = {filt_out[15], filt_out} - {x1_q[15], x1_q};
    assign dy       = {y2_q[15], y2_q} - {y1_q[15], y1_q};
    assign dx       = {x2_q[15], x2_q} - {x1_q[15], x1_q};
    assign prod     = 34'(dy * dx_in);
    assign quot     = (dx == 17'sh0) ? 34'sh0 : prod / 34'(dx);
    assign char_val = 16'(quot + 34'(y1_q));

    // Hysteresis around zero
    logic signed [15:0] lin_val;
    logic signed [15:0] tol_s;
    logic               above_band, below_band;
    logic signed [15:0] hyst_val;
    assign lin_val    = is_char ? char_val : filt_out;
    assign tol_s      = tol_q;
    assign above_band = lin_val > tol_s;
    assign below_band = lin_val < -tol_s;
    // Inside band hold minimum of the last side
    assign hyst_val   = above_band ? lin_val :
                        below_band ? lin_val :
                        (hyst_pos_q ? minout_q : -minout_q);
    // Reset side positive
    always_ff @(posedge clock)
    begin
        if (rst)
            hyst_pos_q <= 1'b1;
        else if (below_band)
            hyst_pos_q <= 1'b0;
        else if (above_band)
            hyst_pos_q <= 1'b1;
    end

    // Pin synchronisers, three flops each
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            syncs_q <= 2'h0;
        end
        else
        begin
            sync1_q <= {multifunction_input_two, multifunction_input_one};
            sync2_q <= sync1_q;
            syncs_q <= sync2_q;
        end
    end

    // Under-range and over-current detection
    logic under, over, start_s;
    // Signed threshold compares
    assign under = cur_q ? (input_one_sample < $signed(`ARC_UNDER_I))
                         : (input_one_sample < $signed(`ARC_UNDER_V));
    assign over  = ((m2_q == ARC_MF_CUR20) || (m2_q == ARC_MF_CUR420) ||
                    (m2_q == ARC_MF_ICHAR)) &&
                   (input_two_analog_value > $signed(`ARC_CUR_MAX));
    assign start_s = start_signal;

    // Supervision flags, independent of enable
    // Mode 2 latch holds stop
    always_comb
    begin
        sup_d = '0;
        sup_d.overcur = over;
        unique case (mon_q)
            ARC_MON_OFF:   ;
            ARC_MON_WARN:  sup_d.warn = under;
            ARC_MON_DECEL:
            begin
                sup_d.warn      = under;
                sup_d.fault     = under;
                sup_d.stop_req  = under || latched_q;
                sup_d.stop_kind = `ARC_STOP_DECEL;
                sup_d.error     = latched_q && (hold_cnt_q >= hold_q);
            end
            ARC_MON_COAST:
            begin
                sup_d.warn      = under;
                sup_d.fault     = under;
                sup_d.stop_req  = under;
                sup_d.stop_kind = `ARC_STOP_COAST;
            end
        endcase
    end

    // Mode 2 stop latch, cleared by start on then off
    // Leaving mode 2 clears
    always_ff @(posedge clock)
    begin
        if (rst || mon_q != ARC_MON_DECEL)
        begin
            latched_q    <= 1'b0;
            hold_cnt_q   <= 32'h0000_0000;
            start_seen_q <= 1'b0;
        end
        else if (under && !latched_q)
        begin
            latched_q  <= 1'b1;
            hold_cnt_q <= 32'h0000_0000;
        end
        else if (latched_q)
        begin
            if (hold_cnt_q < hold_q)
                hold_cnt_q <= hold_cnt_q + 32'h0000_0001;
            if (start_s)
                start_seen_q <= 1'b1;
            else if (start_seen_q && !under)
            begin
                latched_q    <= 1'b0;
                start_seen_q <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            sup_q                   <= '0;
            ref_out                 <= 16'sh0000;
            input_one_digital_value <= 1'b0;
            input_two_digital_value <= 1'b0;
        end
        else
        begin
            sup_q   <= sup_d;
            ref_out <= hyst_val;
            input_one_digital_value <= (m1_q == ARC_MF_DIG_LO) ? ~sync2_q[0] :
                                       (m1_q == ARC_MF_DIG_HI) ?  sync2_q[0] : 1'b0;
            input_two_digital_value <= (m2_q == ARC_MF_DIG_LO) ? ~sync2_q[1] :
                                       (m2_q == ARC_MF_DIG_HI) ?  sync2_q[1] : 1'b0;
        end
    end
    // Flags from sup_q
    assign warn          = sup_q.warn;
    assign fault         = sup_q.fault;
    assign stop_req      = sup_q.stop_req;
    assign stop_kind     = sup_q.stop_kind;
    assign error_flag    = sup_q.error;
    assign overcur_fault = sup_q.overcur;
endmodule : arc_cond

// ==== tb/arc_cond_chk.sv ====
// Concurrent checks on the ports of the analog reference conditioning block
`include "arc_map.svh"
module arc_cond_chk
    import arc_pkg::*;
#(
    parameter int unsigned SAMPLE_CYC = 4  // Cycles between input samples
)(
    // Clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // Register port
    input  wire logic [3:0]          reg_addr,
    input  wire logic [31:0]         reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [31:0]         reg_rdata,
    // Watched inputs
    input  wire logic signed [15:0]  input_one_sample,
    input  wire logic                multifunction_input_one,
    // Watched outputs
    input  wire logic                input_one_digital_value,
    input  wire logic                warn,
    input  wire logic                fault,
    input  wire logic                stop_req,
    input  wire logic [1:0]          stop_kind,
    input  wire logic                error_flag
);
    logic [1:0]  mon_q;    // Shadow of monitoring mode
    logic [1:0]  mon_p;    // Same, one cycle older
    logic [2:0]  m1_q;     // Shadow of input one mode
    logic        pin_q;    // Last input one level
    logic [3:0]  stab_q;   // Cycles pin and mode held still
    logic [31:0] hold_q;   // Shadow of holding time
    logic [31:0] cnt_q;    // Cycles stop request held
    logic        ctrl_wr;  // Control write decode
    logic        hold_wr;  // Holding time write decode
    assign ctrl_wr = reg_wr && (reg_addr == `ARC_OFF_CTRL);
    assign hold_wr = reg_wr && (reg_addr == `ARC_OFF_HOLD);
    // Shadows follow writes; counters track stillness and stop time
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            mon_q  <= `ARC_RST_MON;
            mon_p  <= `ARC_RST_MON;
            m1_q   <= `ARC_RST_M1;
            pin_q  <= 1'b0;
            stab_q <= 4'h0;
            hold_q <= `ARC_RST_HOLD;
            cnt_q  <= 32'h0;
        end
        else
        begin
            mon_q  <= ctrl_wr ? reg_wdata[`ARC_CTRL_MON_LSB +: 2] : mon_q;
            mon_p  <= mon_q;
            m1_q   <= ctrl_wr ? reg_wdata[`ARC_CTRL_M1_LSB +: 3] : m1_q;
            pin_q  <= multifunction_input_one;
            stab_q <= (ctrl_wr || multifunction_input_one != pin_q) ? 4'h0
                    : ((stab_q == 4'h8) ? stab_q : stab_q + 4'h1);
            hold_q <= hold_wr ? reg_wdata : hold_q;
            cnt_q  <= stop_req ? cnt_q + 32'h1 : 32'h0;
        end
    end
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (rst);
    a_mon_off_quiet: assert property ((mon_q == 2'h0 && mon_p == 2'h0) |-> !warn && !fault)
        else $error("flag raised with supervision off");
    a_warn_level: assert property ((mon_q != 2'h0 && mon_p != 2'h0
        && $past(input_one_sample) < $signed(`ARC_UNDER_V)) |-> warn)
        else $error("warn missing on low input");
    a_stop_fault: assert property ((mon_q[1] && mon_p[1]
        && $past(input_one_sample) < $signed(`ARC_UNDER_V)) |-> fault && stop_req)
        else $error("fault or stop missing on low input");
    a_warn_only: assert property ((mon_q == 2'h1 && mon_p == 2'h1) |-> !fault && !stop_req)
        else $error("fault in warning mode");
    a_kind_decel: assert property ((mon_q == 2'h2 && mon_p == 2'h2 && stop_req)
        |-> stop_kind == `ARC_STOP_DECEL)
        else $error("wrong stop kind for decelerate mode");
    a_kind_coast: assert property ((mon_q == 2'h3 && mon_p == 2'h3 && stop_req)
        |-> stop_kind == `ARC_STOP_COAST)
        else $error("wrong stop kind for coast mode");
    a_error_hold: assert property ($rose(error_flag) |-> stop_req && cnt_q + 32'h1 >= hold_q)
        else $error("error flag before holding time");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read cycle");
    a_in1_level: assert property ((stab_q >= 4'h5 && (m1_q == 3'h3 || m1_q == 3'h4))
        |-> input_one_digital_value == (multifunction_input_one ^ (m1_q == 3'h3)))
        else $error("input one digital level wrong");
endmodule : arc_cond_chk
bind arc_cond arc_cond_chk #(.SAMPLE_CYC(SAMPLE_CYC)) chk_u (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_one_sample(input_one_sample),
    .multifunction_input_one(multifunction_input_one),
    .input_one_digital_value(input_one_digital_value), .warn(warn), .fault(fault),
    .stop_req(stop_req), .stop_kind(stop_kind), .error_flag(error_flag)
);

// ==== tb/arc_src.sv ====
// Model of the analog sources and switch contacts feeding the block
module arc_src
    import arc_pkg::*;
(
    // Clock
    input  wire logic          clock,
    // Converter values and contact levels
    output logic signed [15:0] ana_one,
    output logic signed [15:0] ana_two,
    output logic               pin_one,
    output logic               pin_two
);
    timeunit 1ns;
    timeprecision 1ps;
    // In-range levels, contacts open
    initial
    begin
        ana_one = 16'sh2000;
        ana_two = 16'sh2000;
        pin_one = 1'b0;
        pin_two = 1'b0;
    end
    // New levels after lag plus one edges, changed just after an edge
    task automatic drive(input logic signed [15:0] a1, input logic signed [15:0] a2,
                         input logic p1, input logic p2, input int lag);
        repeat (lag) @(posedge clock);
        @(posedge clock);
        ana_one <= a1;
        ana_two <= a2;
        pin_one <= p1;
        pin_two <= p2;
    endtask : drive
endmodule : arc_src

// ==== tb/arc_cond_tb_top.sv ====
// Self-checking bench of the analog reference conditioning block
`include "arc_map.svh"
module arc_cond_tb_top
    import arc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clock = 1'b0;     // 125 MHz clock
    logic               rst = 1'b1;       // Synchronous reset
    logic [3:0]         reg_addr = 4'h0;  // Register port
    logic [31:0]        reg_wdata = 32'h0;
    logic               reg_wr = 1'b0;
    logic               reg_rd = 1'b0;
    logic               start_signal = 1'b0;
    logic [31:0]        reg_rdata;        // Design outputs
    logic [31:0]        rdv;              // Last read value
    logic signed [15:0] ana_one, ana_two, ref_out, r_short;
    logic               pin_one, pin_two, dig_one, dig_two;
    logic               warn, fault, stop_req, error_flag, overcur_fault;
    logic [1:0]         stop_kind;
    int                 err_total = 0;
    int                 checks = 0;
    int                 cyc = 0;
    int                 mon_seq [4] = '{0, 1, 3, 2};
    int                 in2_mode [5] = '{1, 2, 5, 6, 7};
    logic signed [15:0] hyst_in [4] = '{16'sh2000, 16'sh0, 16'she000, 16'sh0};
    logic signed [15:0] hyst_exp [4] = '{16'sh2000, 16'sh0100, 16'she000, 16'shff00};
    arc_src src_u (.clock(clock), .ana_one(ana_one), .ana_two(ana_two), .pin_one(pin_one),
                   .pin_two(pin_two));
    arc_cond #(.SAMPLE_CYC(4)) dut_u (
        .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .input_one_sample(ana_one),
        .input_two_analog_value(ana_two), .multifunction_input_one(pin_one),
        .multifunction_input_two(pin_two), .start_signal(start_signal), .ref_out(ref_out),
        .input_one_digital_value(dig_one), .input_two_digital_value(dig_two), .warn(warn),
        .fault(fault), .stop_req(stop_req), .stop_kind(stop_kind), .error_flag(error_flag),
        .overcur_fault(overcur_fault));
    initial forever #4 clock = ~clock;
    // Hang guard
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_total++;
            final_report();
        end
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    function automatic logic [31:0] bit32(input logic x);
        return {31'h0, x};
    endfunction : bit32
    function automatic logic [31:0] ctrl(input int tc, input int mon, input int m1, input int m2);
        return {17'h0, 3'(m2), 1'b0, 3'(m1), 2'b0, 2'(mon), 4'(tc)};
    endfunction : ctrl
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        rdv = reg_rdata;
    endtask : rd
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : wait_cyc
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : final_report
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rd(`ARC_OFF_CTRL);
        chk("ctrl reset", rdv, 32'h0000_3100);
        rd(`ARC_OFF_TOL);
        chk("tol reset", rdv, {16'h0, `ARC_RST_TOL});
        wr(`ARC_OFF_TOL, 32'h0000_1001);
        rd(`ARC_OFF_TOL);
        chk("tol clip", rdv, {16'h0, `ARC_TOL_MAX});
        wr(4'hf, 32'h0000_5a5a);
        rd(4'hf);
        chk("unmapped", rdv, 32'h0);
        rd(`ARC_OFF_STATUS);
        chk("source code", {24'h0, rdv[15:8]}, 32'h0000_004c);
        chk("in2 default", bit32(dig_two), 32'h1);
        // Digital polarity of both inputs
        for (int m = 3; m <= 4; m++)
            for (int p = 0; p <= 1; p++)
            begin
                wr(`ARC_OFF_CTRL, ctrl(0, 0, m, m));
                src_u.drive(16'sh2000, 16'sh2000, 1'(p), 1'(p), 0);
                wait_cyc(6);
                chk("in1 digital", bit32(dig_one), bit32(1'(p) ^ (m == 3)));
                chk("in2 digital", bit32(dig_two), bit32(1'(p) ^ (m == 3)));
            end
        // Supervision modes, start off
        wr(`ARC_OFF_HOLD, 32'h0000_0014);
        foreach (mon_seq[i])
        begin
            wr(`ARC_OFF_CTRL, ctrl(0, mon_seq[i], 1, 3));
            src_u.drive(16'sh0100, 16'sh2000, 1'b0, 1'b0, i);
            wait_cyc(4);
            chk("warn", bit32(warn), bit32(mon_seq[i] != 0));
            chk("fault", bit32(fault), bit32(mon_seq[i] >= 2));
            chk("stop", bit32(stop_req), bit32(mon_seq[i] >= 2));
            if (mon_seq[i] == 3)
                chk("kind", {30'h0, stop_kind}, {30'h0, `ARC_STOP_COAST});
            if (mon_seq[i] != 2)
                src_u.drive(16'sh2000, 16'sh2000, 1'b0, 1'b0, 0);
            wait_cyc(4);
        end
        chk("kind", {30'h0, stop_kind}, {30'h0, `ARC_STOP_DECEL});
        wait_cyc(10);
        chk("error early", bit32(error_flag), 32'h0);
        wait_cyc(10);
        chk("error late", bit32(error_flag), 32'h1);
        src_u.drive(16'sh2000, 16'sh2000, 1'b0, 1'b0, 0);
        wait_cyc(4);
        chk("stop latched", bit32(stop_req), 32'h1);
        @(posedge clock) start_signal <= 1'b1;
        wait_cyc(4);
        @(posedge clock) start_signal <= 1'b0;
        wait_cyc(4);
        chk("restart", bit32(stop_req), 32'h0);
        // Over-current only in current modes
        foreach (in2_mode[i])
        begin
            wr(`ARC_OFF_CTRL, ctrl(0, 0, 1, in2_mode[i]));
            src_u.drive(16'sh2000, 16'sh7fff, 1'b0, 1'b0, 0);
            wait_cyc(6);
            chk("overcur", bit32(overcur_fault), bit32(in2_mode[i] % 3 == 2 || in2_mode[i] == 7));
            src_u.drive(16'sh2000, 16'sh3000, 1'b0, 1'b0, 0);
            wait_cyc(6);
            chk("overcur clear", bit32(overcur_fault), 32'h0);
        end
        // Hysteresis, point 2
        wr(`ARC_OFF_MINOUT, 32'h0000_0100);
        wr(`ARC_OFF_PT1, 32'h0000_0666);
        wr(`ARC_OFF_CTRL, ctrl(0, 0, 1, 3));
        foreach (hyst_in[i])
        begin
            src_u.drive(hyst_in[i], 16'sh2000, 1'b0, 1'b0, 0);
            wait_cyc(4);
            chk("hyst", {16'h0, ref_out}, {16'h0, hyst_exp[i]});
        end
        wr(`ARC_OFF_CTRL, ctrl(0, 0, 6, 3));
        src_u.drive(`ARC_RST_X2, 16'sh2000, 1'b0, 1'b0, 0);
        wait_cyc(4);
        chk("pt2", {16'h0, ref_out}, {16'h0, `ARC_RST_Y2});
        // Filter bypass against filtered settling
        for (int t = 0; t <= 2; t++)
        begin
            wr(`ARC_OFF_CTRL, ctrl(t, 0, 1, 3));
            src_u.drive(16'sh1000, 16'sh2000, 1'b0, 1'b0, 0);
            wait_cyc(600);
            src_u.drive(16'sh3000, 16'sh2000, 1'b0, 1'b0, 0);
            wait_cyc(10);
            r_short = ref_out;
            wait_cyc(600);
            chk("filter", bit32(r_short === ref_out), bit32(t == 0));
        end
        final_report();
    end
endmodule : arc_cond_tb_top
